// *** ppmc_top.sv ***
// Port power monitor/control block with AXI4-Lite register slave
`timescale 1ns/100ps
// Overview of operation
// - With upstream enumerated offer SDP and CDP; otherwise only DCP.
// - Auto VBUS toggling on after reset; software can switch it off.
// - Auto toggle on: SDP, CDP and CDP/DCP ports power-cycle on any enumeration change.
// - SDP port loses VBUS while not enumerated; regains it on enumeration.
// - CDP/DCP port acts CDP when enumerated, DCP when not.
// - Sample voltage and current of all eight ports plus supply voltage.
// - Voltage then current per port, sequenced across ports; 140 us each.
// - New output = old output plus (sample minus old output) over four.
// - After each update the sequence moves to the next signal.
// - Step response within 10% after 8 samples, 1% after 16.
// - Any raw current sample above the port limit trips the port.
// - Trip sets the overcurrent flag, power drops after the trip delay.
// - Three consecutive overvoltage or negative-current samples cut VBUS.
// - After the fault clears VBUS returns after the recovery delay.
// - Control port is full-speed management only, never hub traffic.
// - Control cable attached: management only there; upstream hub only.
// - Control port unused: management shares the active upstream link.
// - One upstream active; chosen by software or automatically.
// - Automatic selection prefers the primary upstream port when connected.
module ppmc_top #(
	parameter int CONV_CYCLES = ppmc_pkg::CONV_TIME_NS / ppmc_pkg::CLK_PERIOD_NS,
	parameter int TRIP_CYCLES = ppmc_pkg::TRIP_TIME_NS / ppmc_pkg::CLK_PERIOD_NS,
	parameter int RECOVERY_CYCLES = ppmc_pkg::RECOVERY_TIME_NS / ppmc_pkg::CLK_PERIOD_NS,
	parameter int CYCLE_CYCLES = ppmc_pkg::CYCLE_TIME_NS / ppmc_pkg::CLK_PERIOD_NS
) (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic i_AWVALID,
	output logic o_AWREADY,
	input wire logic [7:0] i_AWADDR,
	input wire logic i_WVALID,
	output logic o_WREADY,
	input wire logic [31:0] i_WDATA,
	input wire logic [3:0] i_WSTRB,
	output logic o_BVALID,
	input wire logic i_BREADY,
	output logic [1:0] o_BRESP,
	input wire logic i_ARVALID,
	output logic o_ARREADY,
	input wire logic [7:0] i_ARADDR,
	output logic o_RVALID,
	input wire logic i_RREADY,
	output logic [31:0] o_RDATA,
	output logic [1:0] o_RRESP,
	input wire logic i_UP_ENUM,
	input wire logic i_PRIMARY_UPSTREAM_PORT_CONN,
	input wire logic i_SECONDARY_UPSTREAM_PORT_CONN,
	input wire logic i_CTRL_PORT_CONN,
	input wire logic signed [15:0] i_ADC_DATA,
	output logic [4:0] o_ADC_CHAN,
	output logic o_ADC_START,
	output logic [7:0] o_VBUS_EN,
	output logic [15:0] o_CHG_MODE,
	output logic o_UP_SEL,
	output logic o_MGMT_ON_CTRL,
	output logic o_MGMT_ON_UPSTREAM
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic signed [15:0] filt(input logic signed [15:0] prev, input logic signed [15:0] smp);
		logic signed [16:0] d;
		d = {smp[15], smp} - {prev[15], prev};
		return prev + 16'(d >>> 2);
	endfunction : filt

	function automatic logic [31:0] strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : strb

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ppmc_pkg::ppmc_ctrl_t ctrl;
	logic [7:0] port_en;
	logic [15:0] mode;
	logic [7:0] oc_flag;
	logic [7:0] oc_off;
	logic [15:0] ov_thr;
	logic [15:0] limit [ppmc_pkg::NPORT];
	logic signed [15:0] avg [ppmc_pkg::NSIG];
	logic [ppmc_pkg::CW-1:0] oc_tmr [ppmc_pkg::NPORT];
	logic [ppmc_pkg::CW-1:0] rec_tmr [ppmc_pkg::NPORT];
	logic [1:0] ovc [ppmc_pkg::NPORT];
	logic [1:0] rcc [ppmc_pkg::NPORT];
	logic [7:0] rec_on;
	logic [ppmc_pkg::CW-1:0] conv_cnt;
	logic [4:0] seq;
	logic enum_q;
	logic cyc_on;
	logic [ppmc_pkg::CW-1:0] cyc_cnt;
	logic aw_got;
	logic w_got;
	logic [5:0] aw_idx;
	logic [31:0] wdat;
	logic [3:0] wstb;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire tick = conv_cnt == ppmc_pkg::CW'(CONV_CYCLES - 1);
	wire is_sup = seq == 5'(ppmc_pkg::SUPPLY_SIG);
	wire is_cur = seq[0] & ~is_sup;
	wire [2:0] sport = seq[3:1];
	wire port_tick = tick & ~is_sup;
	wire over_lim = is_cur & (i_ADC_DATA > $signed({1'b0, limit[sport]}));
	wire bad_v = ~is_cur & (i_ADC_DATA > $signed({1'b0, ov_thr}));
	wire bad_i = is_cur & (i_ADC_DATA < 0);
	wire enum_chg = i_UP_ENUM != enum_q;
	wire do_wr = aw_got & w_got & ~o_BVALID;
	wire wr_oc = do_wr & (aw_idx == ppmc_pkg::IDX_OC_FLAG);
	wire [7:0] oc_clr = wr_oc & wstb[0] ? wdat[7:0] : 8'h00;
	wire [7:0] oc_set = port_tick & over_lim ? 8'h01 << sport : 8'h00;
	wire [5:0] ar_idx = i_ARADDR[7:2];
	wire up_pick = ctrl.up_auto ? ~i_PRIMARY_UPSTREAM_PORT_CONN & i_SECONDARY_UPSTREAM_PORT_CONN
		: ctrl.up_manual_sel;
	logic [7:0] fault;
	logic [7:0] vbus;
	logic [15:0] eff_mode;
	logic [31:0] rd_word;
	logic rd_ok;

	// ----------------------------------------------------------------
	// Port power and charging mode
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int p = 0; p < ppmc_pkg::NPORT; p++)
		begin
			fault[p] = ovc[p] == 2'(ppmc_pkg::FAULT_RUN) || rcc[p] == 2'(ppmc_pkg::FAULT_RUN);
			case (ppmc_pkg::ppmc_mode_t'(mode[p*2 +: 2]))
				ppmc_pkg::MODE_SDP: eff_mode[p*2 +: 2] = i_UP_ENUM ? ppmc_pkg::MODE_SDP
					: ppmc_pkg::MODE_DCP;
				ppmc_pkg::MODE_CDP, ppmc_pkg::MODE_CDP_DCP: eff_mode[p*2 +: 2] = i_UP_ENUM
					? ppmc_pkg::MODE_CDP : ppmc_pkg::MODE_DCP;
				default: eff_mode[p*2 +: 2] = ppmc_pkg::MODE_DCP;
			endcase
			vbus[p] = port_en[p] & ~oc_off[p] & ~fault[p] & ~rec_on[p]
				& ~(mode[p*2 +: 2] == ppmc_pkg::MODE_SDP & ~i_UP_ENUM)
				& ~(cyc_on & mode[p*2 +: 2] != ppmc_pkg::MODE_DCP);
		end
	end

	// ----------------------------------------------------------------
	// Measurement sequencer and filter
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			conv_cnt <= '0;
			seq <= '0;
			o_ADC_START <= 1'b0;
			o_ADC_CHAN <= '0;
			for (int k = 0; k < ppmc_pkg::NSIG; k++)
				avg[k] <= '0;
		end
		else
		begin
			conv_cnt <= tick ? '0 : conv_cnt + 1'b1;
			o_ADC_START <= tick;
			if (tick)
			begin
				avg[seq] <= filt(avg[seq], i_ADC_DATA);
				seq <= is_sup ? '0 : seq + 1'b1;
				o_ADC_CHAN <= is_sup ? '0 : seq + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Overcurrent, overvoltage and reverse current
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			oc_flag <= '0;
			oc_off <= '0;
			rec_on <= '0;
			for (int p = 0; p < ppmc_pkg::NPORT; p++)
			begin
				oc_tmr[p] <= '0;
				rec_tmr[p] <= '0;
				ovc[p] <= '0;
				rcc[p] <= '0;
			end
		end
		else
		begin
			oc_flag <= (oc_flag & ~oc_clr) | oc_set;
			for (int p = 0; p < ppmc_pkg::NPORT; p++)
			begin
				if (!oc_flag[p] || oc_off[p])
					oc_tmr[p] <= '0;
				else if (oc_tmr[p] == ppmc_pkg::CW'(TRIP_CYCLES - 1))
					oc_off[p] <= 1'b1;
				else
					oc_tmr[p] <= oc_tmr[p] + 1'b1;
				if (oc_clr[p] && !oc_set[p])
					oc_off[p] <= 1'b0;
				if (port_tick && sport == 3'(p))
				begin
					if (!is_cur)
						ovc[p] <= !bad_v ? 2'h0 : fault[p] ? ovc[p] : ovc[p] + 1'b1;
					else
						rcc[p] <= !bad_i ? 2'h0 : fault[p] ? rcc[p] : rcc[p] + 1'b1;
				end
				if (fault[p])
				begin
					rec_on[p] <= 1'b1;
					rec_tmr[p] <= '0;
				end
				else if (rec_on[p])
				begin
					rec_tmr[p] <= rec_tmr[p] + 1'b1;
					if (rec_tmr[p] == ppmc_pkg::CW'(RECOVERY_CYCLES - 1))
						rec_on[p] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Automatic power cycling on enumeration change
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			enum_q <= 1'b0;
			cyc_on <= 1'b0;
			cyc_cnt <= '0;
		end
		else
		begin
			enum_q <= i_UP_ENUM;
			if (enum_chg && ctrl.auto_toggle)
			begin
				cyc_on <= 1'b1;
				cyc_cnt <= '0;
			end
			else if (cyc_on)
			begin
				cyc_cnt <= cyc_cnt + 1'b1;
				if (cyc_cnt == ppmc_pkg::CW'(CYCLE_CYCLES - 1))
					cyc_on <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			o_VBUS_EN <= '0;
			o_CHG_MODE <= '0;
			o_UP_SEL <= 1'b0;
			o_MGMT_ON_CTRL <= 1'b0;
			o_MGMT_ON_UPSTREAM <= 1'b0;
		end
		else
		begin
			o_VBUS_EN <= vbus;
			o_CHG_MODE <= eff_mode;
			o_UP_SEL <= up_pick;
			o_MGMT_ON_CTRL <= i_CTRL_PORT_CONN;
			o_MGMT_ON_UPSTREAM <= ~i_CTRL_PORT_CONN;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------------------------------
	assign o_AWREADY = ~aw_got & ~o_BVALID;
	assign o_WREADY = ~w_got & ~o_BVALID;
	wire wr_map = aw_idx <= ppmc_pkg::IDX_OV_THR & aw_idx != ppmc_pkg::IDX_STATUS
		& aw_idx != ppmc_pkg::IDX_FAULT | aw_idx[5:3] == ppmc_pkg::IDX_LIMIT0[5:3];

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_idx <= '0;
			wdat <= '0;
			wstb <= '0;
			o_BVALID <= 1'b0;
			o_BRESP <= ppmc_pkg::RESP_OKAY;
			ctrl <= ppmc_pkg::CTRL_RST;
			port_en <= ppmc_pkg::PORT_EN_RST;
			mode <= '0;
			ov_thr <= ppmc_pkg::OV_THR_RST;
			for (int p = 0; p < ppmc_pkg::NPORT; p++)
				limit[p] <= ppmc_pkg::LIMIT_RST;
		end
		else
		begin
			if (i_AWVALID && o_AWREADY)
			begin
				aw_got <= 1'b1;
				aw_idx <= i_AWADDR[7:2];
			end
			if (i_WVALID && o_WREADY)
			begin
				w_got <= 1'b1;
				wdat <= i_WDATA;
				wstb <= i_WSTRB;
			end
			if (do_wr)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				o_BVALID <= 1'b1;
				o_BRESP <= wr_map ? ppmc_pkg::RESP_OKAY : ppmc_pkg::RESP_DECERR;
				case (aw_idx)
					ppmc_pkg::IDX_CTRL: ctrl <= 3'(strb(32'(ctrl), wdat, wstb));
					ppmc_pkg::IDX_PORT_EN: port_en <= 8'(strb(32'(port_en), wdat, wstb));
					ppmc_pkg::IDX_MODE: mode <= 16'(strb(32'(mode), wdat, wstb));
					ppmc_pkg::IDX_OV_THR: ov_thr <= 16'(strb(32'(ov_thr), wdat, wstb));
					default:
						if (aw_idx[5:3] == ppmc_pkg::IDX_LIMIT0[5:3])
							limit[aw_idx[2:0]] <= 16'(strb(32'(limit[aw_idx[2:0]]), wdat, wstb));
				endcase
			end
			else if (o_BVALID && i_BREADY)
				o_BVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------------------------------
	assign o_ARREADY = ~o_RVALID;
	wire [5:0] avg_off = ar_idx - ppmc_pkg::IDX_AVG0;

	always_comb
	begin
		rd_word = '0;
		rd_ok = 1'b1;
		case (ar_idx)
			ppmc_pkg::IDX_CTRL: rd_word = 32'(ctrl);
			ppmc_pkg::IDX_STATUS: rd_word = {27'h0, cyc_on, i_CTRL_PORT_CONN, o_UP_SEL, i_UP_ENUM, 1'b0} >> 1;
			ppmc_pkg::IDX_PORT_EN: rd_word = 32'(port_en);
			ppmc_pkg::IDX_MODE: rd_word = 32'(mode);
			ppmc_pkg::IDX_OC_FLAG: rd_word = 32'(oc_flag);
			ppmc_pkg::IDX_FAULT: rd_word = {8'h0, o_VBUS_EN, rec_on, fault};
			ppmc_pkg::IDX_OV_THR: rd_word = 32'(ov_thr);
			default:
				if (ar_idx[5:3] == ppmc_pkg::IDX_LIMIT0[5:3])
					rd_word = 32'(limit[ar_idx[2:0]]);
				else if (ar_idx >= ppmc_pkg::IDX_AVG0 && avg_off < 6'(ppmc_pkg::NSIG))
					rd_word = 32'(avg[avg_off[4:0]]);
				else
					rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			o_RVALID <= 1'b0;
			o_RDATA <= '0;
			o_RRESP <= ppmc_pkg::RESP_OKAY;
		end
		else if (i_ARVALID && o_ARREADY)
		begin
			o_RVALID <= 1'b1;
			o_RDATA <= rd_word;
			o_RRESP <= rd_ok ? ppmc_pkg::RESP_OKAY : ppmc_pkg::RESP_DECERR;
		end
		else if (o_RVALID && i_RREADY)
			o_RVALID <= 1'b0;
	end
endmodule : ppmc_top

// *** ppmc_pkg.sv ***
// Constants, register map and types for the port power monitor/control block
package ppmc_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NPORT = 8;
	localparam int NSIG = 17;
	localparam int SUPPLY_SIG = 16;
	localparam int CW = 25;
	localparam int FAULT_RUN = 3;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int CONV_TIME_NS = 140000;
	localparam int TRIP_TIME_NS = 1000000;
	localparam int RECOVERY_TIME_NS = 70000000;
	localparam int CYCLE_TIME_NS = 100000000;
	// ----------------------------------------------------------------
	// Register word indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_STATUS = 6'h01;
	localparam logic [5:0] IDX_PORT_EN = 6'h02;
	localparam logic [5:0] IDX_MODE = 6'h03;
	localparam logic [5:0] IDX_OC_FLAG = 6'h04;
	localparam logic [5:0] IDX_FAULT = 6'h05;
	localparam logic [5:0] IDX_OV_THR = 6'h06;
	localparam logic [5:0] IDX_LIMIT0 = 6'h08;
	localparam logic [5:0] IDX_AVG0 = 6'h10;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_EN_RST = 8'hFF;
	localparam logic [15:0] LIMIT_RST = 16'h0FFF;
	localparam logic [15:0] OV_THR_RST = 16'h02A3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_SDP, MODE_CDP, MODE_CDP_DCP, MODE_DCP} ppmc_mode_t;
	typedef struct packed {
		logic up_manual_sel;
		logic up_auto;
		logic auto_toggle;
	} ppmc_ctrl_t;
	localparam ppmc_ctrl_t CTRL_RST = '{up_manual_sel: 1'b0, up_auto: 1'b1, auto_toggle: 1'b1};
endpackage : ppmc_pkg

// *** ppmc_properties.sv ***
// Concurrent checks on the port power monitor/control ports
`timescale 1ns/100ps
module ppmc_properties #(
	parameter int CONV_CYCLES = 20
) (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic i_BREADY,
	input wire logic o_BVALID,
	input wire logic [1:0] o_BRESP,
	input wire logic i_UP_ENUM,
	input wire logic i_PRIMARY_UPSTREAM_PORT_CONN,
	input wire logic i_CTRL_PORT_CONN,
	input wire logic [4:0] o_ADC_CHAN,
	input wire logic o_ADC_START,
	input wire logic [7:0] o_VBUS_EN,
	input wire logic [15:0] o_CHG_MODE,
	input wire logic o_UP_SEL,
	input wire logic o_MGMT_ON_CTRL,
	input wire logic o_MGMT_ON_UPSTREAM
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_ARST_N);
	logic seen;
	logic [4:0] last_chan;
	int gap;
	logic [7:0] cdp_port;
	logic [7:0] sdp_shown;
	for (genvar p = 0; p < 8; p++)
	begin : g_port
		assign cdp_port[p] = o_CHG_MODE[2*p +: 2] == 2'h1;
		assign sdp_shown[p] = o_CHG_MODE[2*p +: 2] == 2'h0;
	end
	// Conversion spacing and channel tracking
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			seen <= 1'b0;
			last_chan <= 5'h00;
			gap <= 0;
		end
		else if (o_ADC_START)
		begin
			seen <= 1'b1;
			last_chan <= o_ADC_CHAN;
			gap <= 0;
		end
		else
			gap <= gap + 1;
	end
	AST_MGMT_CTRL: assert property ($past(I_ARST_N) |-> o_MGMT_ON_CTRL == $past(i_CTRL_PORT_CONN))
		else $error("management path does not follow control cable");
	AST_MGMT_UP: assert property ($past(I_ARST_N) |-> o_MGMT_ON_UPSTREAM != o_MGMT_ON_CTRL)
		else $error("management on both or neither path");
	AST_UP_PRIMARY: assert property ($past(I_ARST_N) && $past(i_PRIMARY_UPSTREAM_PORT_CONN) |-> !o_UP_SEL)
		else $error("secondary upstream chosen while primary connected");
	AST_NO_CDP: assert property ($past(I_ARST_N) && !$past(i_UP_ENUM) |-> cdp_port == 8'h00)
		else $error("charging port mode shown without enumeration");
	AST_SDP_OFF: assert property ($past(I_ARST_N, 2) && !$past(i_UP_ENUM) |->
		($past(sdp_shown) & o_VBUS_EN) == 8'h00)
		else $error("standard port powered without enumeration");
	AST_START_GAP: assert property (o_ADC_START && seen |-> gap == CONV_CYCLES - 1)
		else $error("conversion period wrong");
	AST_CHAN_SEQ: assert property (o_ADC_START && seen |->
		o_ADC_CHAN == (last_chan == 5'h10 ? 5'h00 : last_chan + 5'h01))
		else $error("measurement channel out of sequence");
	AST_BRESP_HOLD: assert property (o_BVALID && !i_BREADY |=> o_BVALID && $stable(o_BRESP))
		else $error("write response dropped before acceptance");
endmodule : ppmc_properties

bind ppmc_top ppmc_properties #(.CONV_CYCLES(CONV_CYCLES)) u_ppmc_properties (.I_REF_CLK, .I_ARST_N, .i_BREADY,
	.o_BVALID, .o_BRESP, .i_UP_ENUM, .i_PRIMARY_UPSTREAM_PORT_CONN, .i_CTRL_PORT_CONN, .o_ADC_CHAN, .o_ADC_START,
	.o_VBUS_EN, .o_CHG_MODE, .o_UP_SEL, .o_MGMT_ON_CTRL, .o_MGMT_ON_UPSTREAM);

// *** ppmc_adc_model.sv ***
// Behavioural sample source for the port voltages, currents and supply
`timescale 1ns/100ps
module ppmc_adc_model (
	input wire logic [4:0] i_chan,
	output logic signed [15:0] o_data
);
	logic signed [15:0] level [17];
	initial
	begin
		foreach (level[c])
			level[c] = 16'sh0000;
	end
	// Out-of-range channel gives a value no filter would expect
	assign o_data = i_chan <= 5'h10 ? level[i_chan] : 16'sh8000;
	task automatic set_level(input int c, input logic signed [15:0] v);
		level[c] <= v;
	endtask : set_level
endmodule : ppmc_adc_model

// *** ppmc_top_tb.sv ***
// Self-checking bench for the port power monitor/control block
`timescale 1ns/100ps
`define CHK(name, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("[ERR] %s expected %h seen %h", name, exp, got); \
		end \
	end
module ppmc_top_tb;
	localparam int CONV = 20;
	localparam int ROUND = CONV * 17;
	localparam logic [1:0] OK = ppmc_pkg::RESP_OKAY;
	int checks_done = 0;
	int err_total = 0;
	logic I_REF_CLK = 1'b0;
	logic I_ARST_N = 1'b0;
	logic i_AWVALID = 1'b0, i_WVALID = 1'b0, i_BREADY = 1'b0, i_ARVALID = 1'b0, i_RREADY = 1'b0;
	logic [7:0] i_AWADDR = 8'h00, i_ARADDR = 8'h00;
	logic [31:0] i_WDATA = 32'h00000000;
	logic [3:0] i_WSTRB = 4'hF;
	logic i_UP_ENUM = 1'b1, i_PRIMARY_UPSTREAM_PORT_CONN = 1'b1;
	logic i_SECONDARY_UPSTREAM_PORT_CONN = 1'b1, i_CTRL_PORT_CONN = 1'b0;
	logic signed [15:0] i_ADC_DATA;
	logic o_AWREADY, o_WREADY, o_BVALID, o_ARREADY, o_RVALID, o_ADC_START, o_UP_SEL;
	logic o_MGMT_ON_CTRL, o_MGMT_ON_UPSTREAM;
	logic [1:0] o_BRESP, o_RRESP;
	logic [31:0] o_RDATA;
	logic [4:0] o_ADC_CHAN;
	logic [7:0] o_VBUS_EN;
	logic [15:0] o_CHG_MODE;
	ppmc_top #(.CONV_CYCLES(CONV), .TRIP_CYCLES(10), .RECOVERY_CYCLES(30), .CYCLE_CYCLES(15)) u_ppmc_top (
		.I_REF_CLK, .I_ARST_N, .i_AWVALID, .o_AWREADY, .i_AWADDR, .i_WVALID, .o_WREADY, .i_WDATA, .i_WSTRB,
		.o_BVALID, .i_BREADY, .o_BRESP, .i_ARVALID, .o_ARREADY, .i_ARADDR, .o_RVALID, .i_RREADY, .o_RDATA,
		.o_RRESP, .i_UP_ENUM, .i_PRIMARY_UPSTREAM_PORT_CONN, .i_SECONDARY_UPSTREAM_PORT_CONN, .i_CTRL_PORT_CONN,
		.i_ADC_DATA, .o_ADC_CHAN, .o_ADC_START, .o_VBUS_EN, .o_CHG_MODE, .o_UP_SEL, .o_MGMT_ON_CTRL,
		.o_MGMT_ON_UPSTREAM);
	ppmc_adc_model u_ppmc_adc_model (.i_chan(o_ADC_CHAN), .o_data(i_ADC_DATA));
	always #2.5 I_REF_CLK = ~I_REF_CLK;
	// ----------------------------------------------------------------
	// Bus and helper tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge I_REF_CLK);
	endtask : cyc
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, b;
		logic [1:0] resp;
		b = 1'b0;
		@(posedge I_REF_CLK);
		i_AWVALID <= 1'b1;
		i_AWADDR <= a;
		i_WVALID <= 1'b1;
		i_WDATA <= d;
		i_BREADY <= 1'b1;
		while (!b)
		begin
			@(negedge I_REF_CLK);
			ta = o_AWREADY;
			tw = o_WREADY;
			b = o_BVALID;
			resp = o_BRESP;
			@(posedge I_REF_CLK);
			if (ta)
				i_AWVALID <= 1'b0;
			if (tw)
				i_WVALID <= 1'b0;
		end
		i_BREADY <= 1'b0;
		`CHK("bresp", r, resp);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, v;
		logic [31:0] got;
		logic [1:0] resp;
		v = 1'b0;
		@(posedge I_REF_CLK);
		i_ARVALID <= 1'b1;
		i_ARADDR <= a;
		i_RREADY <= 1'b1;
		while (!v)
		begin
			@(negedge I_REF_CLK);
			ta = o_ARREADY;
			v = o_RVALID;
			got = o_RDATA;
			resp = o_RRESP;
			@(posedge I_REF_CLK);
			if (ta)
				i_ARVALID <= 1'b0;
		end
		i_RREADY <= 1'b0;
		`CHK("rdata", d, got);
		`CHK("rresp", r, resp);
	endtask : axr
	task automatic vchk(input logic [7:0] v, input logic [7:0] m);
		@(negedge I_REF_CLK);
		`CHK("vbus", v, o_VBUS_EN);
		`CHK("mode", m, o_CHG_MODE[7:0]);
		@(posedge I_REF_CLK);
	endtask : vchk
	task automatic adc(input int c, input logic signed [15:0] v);
		@(posedge I_REF_CLK);
		u_ppmc_adc_model.set_level(c, v);
	endtask : adc
	function automatic int favg(input int s);
		int a;
		a = 0;
		repeat (40) a = a + ((s - a) >>> 2);
		return a;
	endfunction : favg
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		axr(8'h00, 32'h00000003, OK);
		axr(8'h08, {24'h000000, ppmc_pkg::PORT_EN_RST}, OK);
		axr(8'h18, {16'h0000, ppmc_pkg::OV_THR_RST}, OK);
		axr(8'h3C, {16'h0000, ppmc_pkg::LIMIT_RST}, OK);
		axr(8'hFC, 32'h00000000, ppmc_pkg::RESP_DECERR);
		axw(8'h04, 32'h0000000F, ppmc_pkg::RESP_DECERR);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_modes;
		axw(8'h0C, 32'h000000E4, OK);
		cyc(3);
		vchk(8'hFF, 8'hD4);
		i_UP_ENUM <= 1'b0;
		cyc(3);
		vchk(8'h08, 8'hFF);
		cyc(20);
		vchk(8'h0E, 8'hFF);
		i_UP_ENUM <= 1'b1;
		cyc(3);
		vchk(8'h08, 8'hD4);
		cyc(20);
		vchk(8'hFF, 8'hD4);
		$display("t_modes done");
	endtask : t_modes
	task automatic t_no_toggle;
		axw(8'h00, 32'h00000002, OK);
		i_UP_ENUM <= 1'b0;
		cyc(3);
		vchk(8'h0E, 8'hFF);
		i_UP_ENUM <= 1'b1;
		cyc(3);
		vchk(8'hFF, 8'hD4);
		axw(8'h00, 32'h00000003, OK);
		$display("t_no_toggle done");
	endtask : t_no_toggle
	task automatic t_filter;
		adc(0, 16'sh0200);
		adc(1, 16'sh0010);
		adc(16, 16'sh0100);
		cyc(30 * ROUND);
		axr(8'h40, 32'(favg(512)), OK);
		axr(8'h44, 32'(favg(16)), OK);
		axr(8'h80, 32'(favg(256)), OK);
		$display("t_filter done");
	endtask : t_filter
	task automatic t_oc;
		axw(8'h24, 32'h00000100, OK);
		adc(3, 16'sh0100);
		cyc(2 * ROUND);
		axr(8'h10, 32'h00000000, OK);
		adc(3, 16'sh0101);
		cyc(2 * ROUND);
		axr(8'h10, 32'h00000002, OK);
		vchk(8'hFD, 8'hD4);
		adc(3, 16'sh0000);
		axw(8'h10, 32'h00000002, OK);
		cyc(5);
		axr(8'h10, 32'h00000000, OK);
		vchk(8'hFF, 8'hD4);
		$display("t_oc done");
	endtask : t_oc
	task automatic t_ov;
		adc(4, 16'sh02A4);
		adc(7, 16'shFFFF);
		cyc(4 * ROUND);
		vchk(8'hF3, 8'hD4);
		adc(4, 16'sh0200);
		adc(7, 16'sh0000);
		cyc(2 * ROUND);
		vchk(8'hFF, 8'hD4);
		$display("t_ov done");
	endtask : t_ov
	task automatic t_links;
		@(posedge I_REF_CLK);
		i_CTRL_PORT_CONN <= 1'b1;
		i_PRIMARY_UPSTREAM_PORT_CONN <= 1'b0;
		cyc(3);
		@(negedge I_REF_CLK);
		`CHK("mgmt_ctrl", 1'b1, o_MGMT_ON_CTRL);
		`CHK("up_sel", 1'b1, o_UP_SEL);
		axr(8'h04, 32'h00000007, OK);
		axw(8'h00, 32'h00000001, OK);
		@(negedge I_REF_CLK);
		`CHK("up_manual", 1'b0, o_UP_SEL);
		axw(8'h00, 32'h00000003, OK);
		@(posedge I_REF_CLK);
		i_CTRL_PORT_CONN <= 1'b0;
		i_PRIMARY_UPSTREAM_PORT_CONN <= 1'b1;
		cyc(3);
		@(negedge I_REF_CLK);
		`CHK("mgmt_up", 1'b1, o_MGMT_ON_UPSTREAM);
		`CHK("up_sel", 1'b0, o_UP_SEL);
		$display("t_links done");
	endtask : t_links
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (5) @(posedge I_REF_CLK);
		I_ARST_N <= 1'b1;
		t_regs;
		t_modes;
		t_no_toggle;
		t_filter;
		t_oc;
		t_ov;
		t_links;
		tally_and_finish;
	end
	initial
	begin
		#200000;
		err_total++;
		$display("[ERR] watchdog expected done seen hang");
		tally_and_finish;
	end
endmodule : ppmc_top_tb
